/* shared/scrs_pkg.sv */
// Package with constants and types of the clock and reset sequencer
package scrs_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned POR_WAIT_CYC  = 4096;
  localparam int unsigned PIN_LOW_CYC   = 32;
  localparam int unsigned INTERNAL_RESET_SIGNAL_TAIL_CYC = 32;
  localparam int unsigned SHORT_STOP_CYC = 32;
  localparam int unsigned VECTOR_CYC    = 3;
  localparam int unsigned BUS_DIV       = 4;
  localparam int unsigned CNT_W         = 12;
  localparam int unsigned PIN_MIN_CYC   = 4;

  localparam logic [31:0] ADDR_CAUSE  = 32'h0000_0000;
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_MODE   = 32'h0000_000c;

  localparam int unsigned CAUSE_POR   = 7;
  localparam int unsigned CAUSE_PIN   = 6;
  localparam int unsigned CAUSE_WDOG  = 5;
  localparam int unsigned CAUSE_OPC   = 4;
  localparam int unsigned CAUSE_ADDR  = 3;
  localparam int unsigned CAUSE_MON   = 2;
  localparam int unsigned CAUSE_LOW   = 1;
  localparam logic [7:0]  CAUSE_RESET = 8'h80;

  localparam int unsigned CFG_WDOG_DIS  = 0;
  localparam int unsigned CFG_STOP_EN   = 1;
  localparam int unsigned CFG_SHORT_STOP_RECOVERY_CFG     = 2;
  localparam int unsigned CFG_LOW_PWRD  = 3;
  localparam int unsigned CFG_LOW_RSTD  = 4;
  localparam logic [7:0]  CFG_RESET     = 8'h00;

  localparam int unsigned MODE_WAIT    = 0;
  localparam int unsigned MODE_PLL     = 1;
  localparam int unsigned MODE_MONITOR = 2;
  localparam int unsigned MODE_BREAK   = 3;
  localparam logic [7:0]  MODE_RESET   = 8'h00;

  localparam logic [15:0] VEC_USER = 16'hfffe;
  localparam logic [15:0] VEC_MON  = 16'hfefe;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SCRS_RUN, SCRS_LONG_WAIT, SCRS_PIN_LOW, SCRS_INTERNAL_RESET_SIGNAL_TAIL, SCRS_EXT_HOLD,
    SCRS_STOPPED, SCRS_STOP_WAIT
  } scrs_state_t;

  typedef struct packed {
    logic watchdog_ovf;
    logic bad_opcode;
    logic stop_instr;
    logic opcode_fetch;
    logic unmapped;
    logic monitor_entry;
    logic vector_erased;
    logic low_supply;
    logic test_level_voltage;
    logic wake;
  } scrs_events_t;

  typedef struct packed {
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        bus_clk_tick;
    logic        internal_reset_signal;
    logic        halt;
    logic [15:0] reset_vector;
  } scrs_ctrl_t;
endpackage

/* rtl/scrs_sequencer.sv */
// Clock and reset sequencer with AXI4-Lite register access
// Behaviour
// - Bus clock is selected reference over four
// - Power-on/low-supply: clocks held, pin low 4096+32
// - Stop exit waits 4096 or 32 cycles
// - Wait mode stops CPU, peripheral clocks run
// - Resets assert internal reset, pick vector
// - Power-on returns config and mode registers to defaults
// - Internal reset clears counter, pin reset not
// - Each source sets its own cause flag
// - Reset aborts instruction, forces reference clock
// - Pin low halts, except in stop and stop recovery where it is ignored; flag after minimum time
// - Internal reset: pin 32, then 35 more
// - Recovery 4163 or 67 cycles total
// - Power-on: pin low 4096+32, release 35 later
// - Power-on pulse resets, enables clock, flags
// - Watchdog overflow resets unless disabled
// - Test-level voltage in monitor or break mode disables the watchdog
// - Bad opcode resets; stop illegal if disabled
// - Unmapped opcode fetch resets, data access not
// - Low supply resets unless disabled by configuration
// - Monitor entry with erased vectors resets
// - 12-bit reference counter clocks watchdog
// - Stop clears counter; short recovery option
// - Cause register bit layout, bit 0 zero
`timescale 1ns/10ps
module scrs_sequencer
  import scrs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        power_on_pulse,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  input  wire scrs_events_t events,
  output scrs_ctrl_t       ctrl,
  output logic             clock_gen_output_en,
  output logic             watchdog_clk_tick,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam logic [CNT_W-1:0] LONG_LAST  = CNT_W'(POR_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] PIN_LAST   = CNT_W'(PIN_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] TAIL_LAST  = CNT_W'(INTERNAL_RESET_SIGNAL_TAIL_CYC + VECTOR_CYC - 1);
  localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_STOP_CYC - 1);
  localparam logic [CNT_W-1:0] PMIN_LAST  = CNT_W'(PIN_MIN_CYC - 1);
  localparam logic [1:0]       DIV_LAST   = 2'(BUS_DIV - 1);

  // Byte address to word select, shared by read and write decode
  function automatic logic [2:0] addr_sel(input logic [31:0] a);
    if (a == ADDR_CAUSE) begin
      return 3'h1;
    end else if (a == ADDR_CONFIG) begin
      return 3'h2;
    end else if (a == ADDR_STATUS) begin
      return 3'h3;
    end else if (a == ADDR_MODE) begin
      return 3'h4;
    end else begin
      return 3'h0;
    end
  endfunction

  scrs_state_t      state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] phase, next_phase;
  logic [CNT_W-1:0] pin_cnt, next_pin_cnt;
  logic [1:0]       div, next_div;
  logic [7:0]       cause, next_cause;
  logic [7:0]       config_register_one, next_cfg;
  logic [7:0]       mode, next_mode;
  logic             cnt_wrap, next_cnt_wrap;
  logic             clk_gen_on, next_clk_gen_on;
  logic             aw_held, next_aw_held;
  logic             w_held, next_w_held;
  logic [31:0]      aw_addr, next_aw_addr;
  logic [31:0]      w_data, next_w_data;
  logic [3:0]       w_strb, next_w_strb;
  logic             bvalid, next_bvalid;
  logic [1:0]       bresp, next_bresp;
  logic             rvalid, next_rvalid;
  logic [31:0]      rdata, next_rdata;
  logic [1:0]       rresp, next_rresp;

  logic       wdog_enabled;
  logic       src_wdog, src_opc, src_addr, src_mon, src_low, src_por;
  logic       any_internal, long_source;
  logic       do_write;
  logic [2:0] wsel;
  logic [2:0] rsel;

  always_comb begin
    wdog_enabled = !config_register_one[CFG_WDOG_DIS]
                   && !(events.test_level_voltage
                        && (mode[MODE_MONITOR] || mode[MODE_BREAK]));
    src_wdog = events.watchdog_ovf && wdog_enabled;
    src_opc  = events.bad_opcode
               || (events.stop_instr && !config_register_one[CFG_STOP_EN]);
    src_addr = events.unmapped && events.opcode_fetch;
    src_mon  = events.monitor_entry && events.vector_erased;
    src_low  = events.low_supply && !config_register_one[CFG_LOW_PWRD]
               && !config_register_one[CFG_LOW_RSTD];
    src_por  = power_on_pulse;
    long_source  = src_por || src_low;
    any_internal = long_source || src_wdog || src_opc || src_addr || src_mon;
  end

  // Reset sequencing and the 12-bit reference counter
  always_comb begin
    next_state      = state;
    next_cnt        = cnt + CNT_W'(1);
    next_cnt_wrap   = (cnt == {CNT_W{1'b1}});
    next_phase      = phase + CNT_W'(1);
    next_pin_cnt    = pin_cnt;
    next_cause      = cause;
    next_div        = div + 2'(1);
    next_clk_gen_on = clk_gen_on;
    if (any_internal) begin
      next_cnt   = '0;
      next_phase = '0;
      next_div   = '0;
      next_cause = {src_por, 1'b0, src_wdog, src_opc, src_addr, src_mon, src_low, 1'b0};
      next_clk_gen_on = src_por ? 1'b1 : clk_gen_on;
      next_state = long_source ? SCRS_LONG_WAIT : SCRS_PIN_LOW;
    end else begin
      case (state)
        SCRS_RUN: begin
          if (!reset_pin_in) begin
            next_state   = SCRS_EXT_HOLD;
            next_pin_cnt = '0;
          end else if (events.stop_instr) begin
            next_cnt   = '0;
            next_state = SCRS_STOPPED;
          end
        end
        SCRS_LONG_WAIT: begin
          if (phase == LONG_LAST) begin
            next_phase = '0;
            next_state = SCRS_PIN_LOW;
          end
        end
        SCRS_PIN_LOW: begin
          if (phase == PIN_LAST) begin
            next_phase = '0;
            next_state = SCRS_INTERNAL_RESET_SIGNAL_TAIL;
          end
        end
        SCRS_INTERNAL_RESET_SIGNAL_TAIL: begin
          if (phase == TAIL_LAST) begin
            next_state = SCRS_RUN;
          end
        end
        SCRS_EXT_HOLD: begin
          next_div = '0;
          if (pin_cnt != PMIN_LAST) begin
            next_pin_cnt = pin_cnt + CNT_W'(1);
          end
          if (reset_pin_in) begin
            if (pin_cnt == PMIN_LAST) begin
              next_cause = 8'h00;
              next_cause[CAUSE_PIN] = 1'b1;
            end
            next_phase = '0;
            next_state = SCRS_INTERNAL_RESET_SIGNAL_TAIL;
          end
        end
        SCRS_STOPPED: begin
          if (events.wake) begin
            next_cnt   = '0;
            next_state = SCRS_STOP_WAIT;
          end
        end
        SCRS_STOP_WAIT: begin
          if (config_register_one[CFG_SHORT_STOP_RECOVERY_CFG] ? (cnt == SHORT_LAST) : (cnt == LONG_LAST)) begin
            next_state = SCRS_RUN;
          end
        end
        default: next_state = SCRS_RUN;
      endcase
    end
  end

  always_comb begin
    ctrl.bus_clk_tick = (div == DIV_LAST);
    ctrl.internal_reset_signal = (state == SCRS_LONG_WAIT) || (state == SCRS_PIN_LOW)
                                 || (state == SCRS_INTERNAL_RESET_SIGNAL_TAIL) || (state == SCRS_EXT_HOLD);
    ctrl.halt = ctrl.internal_reset_signal;
    ctrl.periph_clk_en = (state == SCRS_RUN);
    ctrl.cpu_clk_en = (state == SCRS_RUN) && !mode[MODE_WAIT];
    ctrl.reset_vector = mode[MODE_MONITOR] ? VEC_MON : VEC_USER;
    reset_pin_out = 1'b0;
    reset_pin_oe  = (state == SCRS_LONG_WAIT) || (state == SCRS_PIN_LOW);
    clock_gen_output_en = clk_gen_on;
    watchdog_clk_tick = cnt_wrap;
  end

  // AXI4-Lite slave
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_cfg     = config_register_one;
    next_mode    = mode;
    s_axi_awready = !aw_held && !bvalid;
    s_axi_wready  = !w_held && !bvalid;
    s_axi_arready = !rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held;
    wsel = addr_sel(aw_addr);
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wsel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
      if (w_strb[0] && wsel == 3'h2) begin
        next_cfg = w_data[7:0];
      end else if (w_strb[0] && wsel == 3'h4) begin
        next_mode = w_data[7:0];
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    rsel = addr_sel(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (rsel == 3'h1) begin
        next_rdata = {24'h000000, cause};
      end else if (rsel == 3'h2) begin
        next_rdata = {24'h000000, config_register_one};
      end else if (rsel == 3'h3) begin
        next_rdata = {17'h00000, ctrl.cpu_clk_en, ctrl.periph_clk_en,
                      ctrl.internal_reset_signal, cnt};
      end else if (rsel == 3'h4) begin
        next_rdata = {24'h000000, mode};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (power_on_pulse) begin
      next_cfg  = CFG_RESET;
      next_mode = MODE_RESET;
    end
    s_axi_bvalid = bvalid;
    s_axi_bresp  = bresp;
    s_axi_rvalid = rvalid;
    s_axi_rdata  = rdata;
    s_axi_rresp  = rresp;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state      <= SCRS_LONG_WAIT;
      cnt        <= '0;
      phase      <= '0;
      pin_cnt    <= '0;
      div        <= '0;
      cause      <= CAUSE_RESET;
      config_register_one <= CFG_RESET;
      mode       <= MODE_RESET;
      cnt_wrap   <= 1'b0;
      clk_gen_on <= 1'b1;
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_addr    <= '0;
      w_data     <= '0;
      w_strb     <= '0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= RESP_OKAY;
    end else if (clk_en) begin
      state      <= next_state;
      cnt        <= next_cnt;
      phase      <= next_phase;
      pin_cnt    <= next_pin_cnt;
      div        <= next_div;
      cause      <= next_cause;
      config_register_one <= next_cfg;
      mode       <= next_mode;
      cnt_wrap   <= next_cnt_wrap;
      clk_gen_on <= next_clk_gen_on;
      aw_held    <= next_aw_held;
      w_held     <= next_w_held;
      aw_addr    <= next_aw_addr;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
    end
  end
endmodule

/* dv/scrs_asserts.sv */
// Port-level assertion checker of the clock and reset sequencer
`timescale 1ns/10ps
module scrs_asserts
  import scrs_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire logic         reset_pin_in,
  input wire logic         reset_pin_oe,
  input wire scrs_events_t events,
  input wire scrs_ctrl_t   ctrl,
  input wire logic         clock_gen_output_en,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [31:0]  s_axi_rdata
);
  localparam int TAIL = INTERNAL_RESET_SIGNAL_TAIL_CYC + VECTOR_CYC;
  logic [12:0] oe_run;
  logic [12:0] tail_run;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Saturating lengths of the pin-low phase and of the time since it ended
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oe_run   <= '0;
      tail_run <= '0;
    end else begin
      oe_run   <= reset_pin_oe ? oe_run + {12'h000, ~&oe_run} : '0;
      tail_run <= reset_pin_oe ? '0 : tail_run + {12'h000, ~&tail_run};
    end
  end
  AST_OE_LEN: assert property ($fell(reset_pin_oe) |-> oe_run == 13'h20 || oe_run >= 13'h1018)
    else $error("pin low phase has the wrong length");
  AST_TAIL_LEN: assert property ($fell(ctrl.internal_reset_signal) |-> tail_run == TAIL || tail_run > 13'h3c)
    else $error("reset tail has the wrong length");
  AST_PIN_HALT: assert property (reset_pin_oe |-> ctrl.halt && ctrl.internal_reset_signal && !ctrl.periph_clk_en)
    else $error("clocks run while the pin is driven");
  AST_CPU_WAIT: assert property (ctrl.cpu_clk_en |-> ctrl.periph_clk_en && !ctrl.halt)
    else $error("cpu clock without peripheral clock");
  AST_VEC: assert property (ctrl.reset_vector == VEC_USER || ctrl.reset_vector == VEC_MON)
    else $error("bad reset vector");
  AST_OPC_RST: assert property (ctrl.periph_clk_en && events.bad_opcode |=> reset_pin_oe)
    else $error("bad opcode did not reset");
  AST_PIN_STOP: assert property (ctrl.periph_clk_en && !reset_pin_in |=> ctrl.halt)
    else $error("pin low did not halt");
  AST_TICK: assert property (ctrl.bus_clk_tick |=> !ctrl.bus_clk_tick [*3])
    else $error("bus ticks too close");
  AST_GEN_EN: assert property (clock_gen_output_en)
    else $error("clock generator output disabled");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind scrs_sequencer scrs_asserts u_asserts (
  .clk_sys, .rst_n, .reset_pin_in, .reset_pin_oe, .events, .ctrl, .clock_gen_output_en,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

/* dv/scrs_pin_partner.sv */
// External chip and pull-up on the open-drain reset pin
`timescale 1ns/10ps
module scrs_pin_partner (
  input  wire logic       clk_sys,
  input  wire logic       reset_pin_oe,
  input  wire logic       reset_pin_out,
  input  wire logic       pull_go,
  input  wire logic [7:0] pull_len,
  output logic            reset_pin_in
);
  logic [7:0] left = 8'h00;
  always_ff @(posedge clk_sys) begin
    if (pull_go) begin
      left <= pull_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Any party pulling low wins, else the pull-up holds the pin high
  assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || left != 8'h00) ? 1'b0 : 1'b1;
endmodule

/* dv/testbench.sv */
// Self-checking bench of the clock and reset sequencer
`timescale 1ns/10ps
module testbench
  import scrs_pkg::*;
;
  localparam int TAIL = INTERNAL_RESET_SIGNAL_TAIL_CYC + VECTOR_CYC;
  localparam int LONG = POR_WAIT_CYC + PIN_LOW_CYC;
  logic         clk_sys = 1'b0;
  logic         rst_n, clk_en, por, go, pin_in, pin_out, pin_oe, gen_en, wt;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic [31:0]  awaddr, wdata, araddr, rdata, cz;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic [7:0]   pl;
  scrs_events_t ev;
  scrs_ctrl_t   ctrl;
  int           seed, n;
  int           errors = 0, compares = 0, cyc = 0;
  scrs_events_t src [4] = '{10'h200, 10'h100, 10'h060, 10'h018};
  int           cbit [4] = '{CAUSE_WDOG, CAUSE_OPC, CAUSE_ADDR, CAUSE_MON};

  scrs_sequencer uut (
    .clk_sys, .rst_n, .clk_en, .power_on_pulse(por), .reset_pin_in(pin_in),
    .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .events(ev), .ctrl,
    .clock_gen_output_en(gen_en), .watchdog_clk_tick(wt), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  scrs_pin_partner u_pin (
    .clk_sys, .reset_pin_oe(pin_oe), .reset_pin_out(pin_out), .pull_go(go),
    .pull_len(pl), .reset_pin_in(pin_in)
  );

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      finish_test;
    end
  end

  function automatic logic [31:0] flag(input int i);
    return 32'h1 << i;
  endfunction

  task automatic finish_test;
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (tb !== 1'b1);
    chk(r, er);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er,
                     input logic [31:0] m = 32'hffffffff);
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tb = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end while (tb !== 1'b1);
    chk(d & m, e);
    chk(r, er);
  endtask

  task automatic pulse(input scrs_events_t e, input logic p);
    @(posedge clk_sys);
    ev  <= e;
    por <= p;
    @(posedge clk_sys);
    ev  <= '0;
    por <= 1'b0;
  endtask

  // Pulses a source, then times the pin-low phase and the reset tail
  task automatic fire(input scrs_events_t e, input logic p, input int n_oe, input int cb);
    int w, a, b;
    w = 0;
    a = 0;
    b = 0;
    if (e != '0 || p) pulse(e, p);
    @(negedge clk_sys);
    while (ctrl.internal_reset_signal !== 1'b1 && w < 6) begin
      w++;
      @(negedge clk_sys);
    end
    while (pin_oe === 1'b1) begin
      a++;
      @(negedge clk_sys);
    end
    while (ctrl.internal_reset_signal === 1'b1) begin
      b++;
      @(negedge clk_sys);
    end
    chk(a, n_oe);
    chk(b, n_oe != 0 ? TAIL : 0);
    if (n_oe != 0) cz = flag(cb);
    rdc(ADDR_CAUSE, cz, RESP_OKAY);
  endtask

  initial begin
    seed = 32'hbcfb;
    {rst_n, por, go, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    clk_en = 1'b1;
    ev = '0;
    pl = 8'h00;
    wstrb = 4'hf;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    fire('0, 1'b0, LONG, CAUSE_POR);
    chk(gen_en, 1'b1);
    chk(pin_out, 1'b0);
    // One full turn of the free-running counter gives exactly one watchdog tick
    n = 0;
    repeat (1 << CNT_W) begin
      @(negedge clk_sys);
      if (wt === 1'b1) n++;
    end
    chk(n, 1);
    n = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (ctrl.bus_clk_tick === 1'b1) n++;
    end
    chk(n, 40 / BUS_DIV);
    wrc(ADDR_MODE, flag(MODE_WAIT), RESP_OKAY);
    @(negedge clk_sys);
    chk({ctrl.cpu_clk_en, ctrl.periph_clk_en}, 2'b01);
    wrc(ADDR_MODE, flag(MODE_MONITOR), RESP_OKAY);
    @(negedge clk_sys);
    chk(ctrl.reset_vector, VEC_MON);
    rdc(32'h10, 32'h0, RESP_SLVERR);
    wrc(32'h14, 32'hff, RESP_SLVERR);
    wrc(ADDR_CAUSE, 32'h0, RESP_OKAY);
    fire(10'h202, 1'b0, 0, 0);
    wrc(ADDR_MODE, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      fire(src[i], 1'b0, PIN_LOW_CYC, cbit[i]);
    end
    rdc(ADDR_STATUS, 32'h6000, RESP_OKAY, 32'h7f80);
    fire(10'h080, 1'b0, PIN_LOW_CYC, CAUSE_OPC);
    fire(10'h020, 1'b0, 0, 0);
    wrc(ADDR_CONFIG, flag(CFG_WDOG_DIS), RESP_OKAY);
    fire(10'h200, 1'b0, 0, 0);
    @(posedge clk_sys);
    pl <= 8'h08 + 8'($unsigned($random(seed)) % 32);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(ctrl.halt, 1'b1);
    repeat (90) @(negedge clk_sys);
    cz = flag(CAUSE_PIN);
    rdc(ADDR_CAUSE, cz, RESP_OKAY);
    for (int s = 0; s < 2; s++) begin
      int e;
      e = s != 0 ? SHORT_STOP_CYC : POR_WAIT_CYC;
      wrc(ADDR_CONFIG, flag(CFG_STOP_EN) | (s != 0 ? flag(CFG_SHORT_STOP_RECOVERY_CFG) : 32'h0), RESP_OKAY);
      pulse(10'h080, 1'b0);
      repeat (4 + $unsigned($random(seed)) % 8) @(negedge clk_sys);
      chk(ctrl.periph_clk_en, 1'b0);
      pulse(10'h001, 1'b0);
      n = 0;
      @(negedge clk_sys);
      while (ctrl.periph_clk_en !== 1'b1) begin
        n++;
        @(negedge clk_sys);
      end
      chk(n > e - 3 && n < e + 3, 1'b1);
    end
    wrc(ADDR_CONFIG, flag(CFG_LOW_RSTD), RESP_OKAY);
    fire(10'h004, 1'b0, 0, 0);
    wrc(ADDR_MODE, flag(MODE_MONITOR), RESP_OKAY);
    fire('0, 1'b1, LONG, CAUSE_POR);
    rdc(ADDR_CONFIG, 32'h0, RESP_OKAY);
    rdc(ADDR_MODE, 32'h0, RESP_OKAY);
    fire(10'h004, 1'b0, LONG, CAUSE_LOW);
    finish_test;
  end
endmodule
